/* File: rtl/nvmcri_pkg.sv */
package nvmcri_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_COMMAND_CONTROL       = 6'h00;
  localparam logic [5:0] OFF_CONFIGURATION_CONTROL = 6'h04;
  localparam logic [5:0] OFF_GEOMETRY_PARAMETERS   = 6'h08;
  localparam logic [5:0] OFF_IRQ_ENABLE_CLEAR      = 6'h0c;
  localparam logic [5:0] OFF_IRQ_ENABLE_SET        = 6'h10;
  localparam logic [5:0] OFF_IRQ_FLAGS             = 6'h14;
  localparam logic [5:0] OFF_CONTROLLER_STATUS     = 6'h18;
  localparam logic [5:0] OFF_TARGET_ADDRESS        = 6'h1c;
  localparam logic [5:0] OFF_REGION_LOCK_STATE     = 6'h20;
  localparam logic [5:0] OFF_PAGE_BUFFER_LOAD_LOW  = 6'h28;
  localparam logic [5:0] OFF_PAGE_BUFFER_LOAD_HIGH = 6'h2c;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          CMD_LSB          = 0;
  localparam int          CMD_MSB          = 6;
  localparam int          KEY_LSB          = 8;
  localparam int          KEY_MSB          = 15;
  localparam logic [7:0]  EXECUTION_KEY    = 8'ha5;
  localparam logic [15:0] CTRL_RESET       = 16'h0000;
  localparam logic [31:0] CONFIG_RESET     = 32'h0000_0080;
  localparam logic [31:0] CONFIG_MASK      = 32'h000f_039e;
  localparam int          IRQ_READY_BIT    = 0;
  localparam int          IRQ_ERROR_BIT    = 1;
  localparam int          ST_PROG_ERR_BIT  = 2;
  localparam int          ST_LOCK_ERR_BIT  = 3;
  localparam int          ST_NVM_ERR_BIT   = 4;
  localparam logic [31:0] ADDR_MASK        = 32'h003f_ffff;
  localparam int          ROW_WORDS_LOG2   = 7;
  localparam int          REGION_SEL_LSB   = 12;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] CMD_ROW_ERASE     = 7'h02;
  localparam logic [6:0] CMD_PAGE_WRITE    = 7'h04;
  localparam logic [6:0] CMD_AUX_ERASE     = 7'h05;
  localparam logic [6:0] CMD_AUX_WRITE     = 7'h06;
  localparam logic [6:0] CMD_DF_ERASE      = 7'h1a;
  localparam logic [6:0] CMD_DF_WRITE      = 7'h1c;
  localparam logic [6:0] CMD_LOCK_REGION   = 7'h40;
  localparam logic [6:0] CMD_UNLOCK_REGION = 7'h41;
  localparam logic [6:0] CMD_BUFFER_CLEAR  = 7'h44;
  localparam logic [6:0] CMD_CACHE_INVAL   = 7'h46;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS  = 2000;
  localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PENDING = 2'b01,
    ST_BUSY    = 2'b10
  } nvmcri_state_t;

endpackage : nvmcri_pkg

/* File: rtl/nvmcri_cmd_decode.sv */
`timescale 1ns/1ns
module nvmcri_cmd_decode (
  // command code
  input  wire logic [6:0] cmd_code,
  // decoded class
  output logic            cmd_valid,
  output logic            cmd_is_erase,
  output logic            cmd_is_write,
  output logic            cmd_is_lock,
  output logic            cmd_is_unlock,
  output logic            cmd_is_buf_clear,
  output logic            cmd_is_array_op
);

  always_comb begin
    cmd_valid        = 1'b1;
    cmd_is_erase     = 1'b0;
    cmd_is_write     = 1'b0;
    cmd_is_lock      = 1'b0;
    cmd_is_unlock    = 1'b0;
    cmd_is_buf_clear = 1'b0;
    unique case (cmd_code)
      nvmcri_pkg::CMD_ROW_ERASE,
      nvmcri_pkg::CMD_AUX_ERASE,
      nvmcri_pkg::CMD_DF_ERASE:      cmd_is_erase = 1'b1;     // R11
      nvmcri_pkg::CMD_PAGE_WRITE,
      nvmcri_pkg::CMD_AUX_WRITE,
      nvmcri_pkg::CMD_DF_WRITE:      cmd_is_write = 1'b1;     // R11
      nvmcri_pkg::CMD_LOCK_REGION:   cmd_is_lock = 1'b1;      // R11
      nvmcri_pkg::CMD_UNLOCK_REGION: cmd_is_unlock = 1'b1;    // R11
      nvmcri_pkg::CMD_BUFFER_CLEAR:  cmd_is_buf_clear = 1'b1; // R11
      nvmcri_pkg::CMD_CACHE_INVAL:   cmd_valid = 1'b1;        // R11
      default:                       cmd_valid = 1'b0;        // R11
    endcase
    cmd_is_array_op = cmd_is_erase | cmd_is_write;
  end

endmodule : nvmcri_cmd_decode

/* File: rtl/nvmcri_top.sv */
`timescale 1ns/1ns
//
// Summary of operation
// R1: a command runs only when the key field of the same control write equals 0xa5.
// R2: a control write with any other key is discarded and sets the programming error bit.
// R3: a command written while an earlier one is still in progress sets the programming error bit.
// R4: software writes key and command code together in one register write.
// R5: a memory-bus access in the same cycle as a command write is served first.
// R6: a deferred command starts only once the array and the memory bus are both idle.
// R7: software issues a command only while the ready flag reads 1.
// R8: bit 0 of the key field reads 1 until the command is issued to the array, then 0; the code also clears it for a locked-region erase or reserved code.
// R9: the target address field counts 16-bit units, not bytes.
// R10: the control register holds a 7-bit code in bits 6:0 and 8-bit key in 15:8, reset zero, rw.
// R11: codes decode to row erase, page write, aux erase/write, data erase/write, lock, unlock,
//      buffer clear and cache invalidate; other codes are reserved.
// R12: ready stays 0 while programming runs and memory-bus accesses to the array stall.
// R13: an erase aimed at a locked region is not done and sets the lock error bit.
// R14: writing 1 to an enable-set bit enables that interrupt, to enable-clear disables it.
// R15: the interrupt request is high while a flag and its enable bit are both set.
//
module nvmcri_top #(
  parameter int PROG_CYCLES = nvmcri_pkg::PROG_CYCLES,
  parameter int NUM_REGIONS = 16
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // peripheral register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [5:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // memory bus activity towards the array
  input  wire logic        mem_access,
  output logic             mem_stall,
  // array command port
  output logic             array_cmd_start,
  output logic [6:0]       array_cmd_code,
  output logic [21:0]      array_word_addr,
  output logic [22:0]      array_byte_addr,
  input  wire logic        array_busy,
  // interrupt
  output logic             irq
);

  // --------------------------------------------------------------
  // register bus decode
  // --------------------------------------------------------------
  logic wr_en;
  logic rd_sel;
  assign wr_en   = psel & penable & pwrite;
  assign rd_sel  = psel & ~pwrite;
  // no wait states: every register answers in its access phase
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  logic wr_ctrl;
  logic wr_key_ok;
  assign wr_ctrl   = wr_en && (paddr == nvmcri_pkg::OFF_COMMAND_CONTROL);
  assign wr_key_ok = pwdata[nvmcri_pkg::KEY_MSB:nvmcri_pkg::KEY_LSB] == nvmcri_pkg::EXECUTION_KEY;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  nvmcri_pkg::nvmcri_state_t state_reg, state_next;
  logic [15:0]            ctrl_reg, ctrl_next;
  logic [31:0]            config_reg, config_next;
  logic [21:0]            addr_reg, addr_next;
  logic [1:0]             ien_reg, ien_next;
  logic                   ready_reg, ready_next;
  logic                   error_flag_reg, error_flag_next;
  logic                   prog_err_reg, prog_err_next;
  logic                   lock_err_reg, lock_err_next;
  logic [NUM_REGIONS-1:0] lock_reg, lock_next;
  logic [15:0]            count_reg, count_next;
  logic                   start_reg, start_next;

  logic cmd_valid;
  logic cmd_is_erase;
  logic cmd_is_write;
  logic cmd_is_lock;
  logic cmd_is_unlock;
  logic cmd_is_buf_clear;
  logic cmd_is_array_op;

  nvmcri_cmd_decode u_decode (
    .cmd_code         (ctrl_reg[nvmcri_pkg::CMD_MSB:nvmcri_pkg::CMD_LSB]),
    .cmd_valid        (cmd_valid),
    .cmd_is_erase     (cmd_is_erase),
    .cmd_is_write     (cmd_is_write),
    .cmd_is_lock      (cmd_is_lock),
    .cmd_is_unlock    (cmd_is_unlock),
    .cmd_is_buf_clear (cmd_is_buf_clear),
    .cmd_is_array_op  (cmd_is_array_op)
  );

  // region of the current target, from the word address
  localparam int RIDX_W = $clog2(NUM_REGIONS);
  logic [$clog2(NUM_REGIONS)-1:0] region_idx;
  assign region_idx = addr_reg[nvmcri_pkg::REGION_SEL_LSB +: $clog2(NUM_REGIONS)];

  logic target_locked;
  assign target_locked = lock_reg[region_idx];

  logic lock_upd;
  logic lock_val;

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------
  always_comb begin
    state_next      = state_reg;
    ctrl_next       = ctrl_reg;
    config_next     = config_reg;
    addr_next       = addr_reg;
    ready_next      = ready_reg;
    error_flag_next = error_flag_reg;
    prog_err_next   = prog_err_reg;
    lock_err_next   = lock_err_reg;
    lock_upd        = 1'b0;
    lock_val        = 1'b0;
    count_next      = count_reg;
    start_next      = 1'b0;

    // software side writes; hardware sets below take precedence
    if (wr_en) begin
      unique case (paddr)
        nvmcri_pkg::OFF_CONFIGURATION_CONTROL:
          config_next = pwdata & nvmcri_pkg::CONFIG_MASK;
        nvmcri_pkg::OFF_TARGET_ADDRESS:
          addr_next = pwdata[21:0];
        nvmcri_pkg::OFF_IRQ_FLAGS:
          error_flag_next = error_flag_reg & ~pwdata[nvmcri_pkg::IRQ_ERROR_BIT];
        nvmcri_pkg::OFF_CONTROLLER_STATUS: begin
          prog_err_next = prog_err_reg & ~pwdata[nvmcri_pkg::ST_PROG_ERR_BIT];
          lock_err_next = lock_err_reg & ~pwdata[nvmcri_pkg::ST_LOCK_ERR_BIT];
        end
        default: ;
      endcase
    end

    if (wr_ctrl) begin
      if (!wr_key_ok) begin
        prog_err_next   = 1'b1;                                       // R2
        error_flag_next = 1'b1;
      end else if (state_reg != nvmcri_pkg::ST_IDLE) begin
        prog_err_next   = 1'b1;                                       // R3
        error_flag_next = 1'b1;
      end else begin
        ctrl_next  = pwdata[15:0] & 16'hff7f;                         // R1 R10
        state_next = nvmcri_pkg::ST_PENDING;
        ready_next = 1'b0;                                            // R12
      end
    end

    unique case (state_reg)
      nvmcri_pkg::ST_IDLE: ;
      nvmcri_pkg::ST_PENDING: begin
        // a memory-bus access wins this cycle; issue waits for idle
        if (!mem_access && !array_busy) begin                         // R5 R6
          ctrl_next[nvmcri_pkg::KEY_LSB] = 1'b0;                      // R8
          if (cmd_is_erase && target_locked) begin
            lock_err_next   = 1'b1;                                   // R13
            error_flag_next = 1'b1;
            state_next      = nvmcri_pkg::ST_IDLE;
            ready_next      = 1'b1;
          end else if (!cmd_valid) begin
            prog_err_next   = 1'b1;
            error_flag_next = 1'b1;
            state_next      = nvmcri_pkg::ST_IDLE;
            ready_next      = 1'b1;
          end else begin
            if (cmd_is_lock || cmd_is_unlock) begin
              lock_upd = 1'b1;
              lock_val = cmd_is_lock;
            end
            start_next = 1'b1;
            count_next = cmd_is_array_op ? 16'(PROG_CYCLES) : 16'h0001;
            state_next = nvmcri_pkg::ST_BUSY;
          end
        end
      end
      nvmcri_pkg::ST_BUSY: begin
        if (count_reg != 16'h0000) begin
          count_next = count_reg - 16'h0001;
        end else if (!array_busy) begin
          state_next = nvmcri_pkg::ST_IDLE;
          ready_next = 1'b1;
        end
      end
      default: state_next = nvmcri_pkg::ST_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg      <= nvmcri_pkg::ST_IDLE;
      ctrl_reg       <= nvmcri_pkg::CTRL_RESET;                      // R10
      config_reg     <= nvmcri_pkg::CONFIG_RESET;
      addr_reg       <= 22'h000000;
      ready_reg      <= 1'b1;
      error_flag_reg <= 1'b0;
      prog_err_reg   <= 1'b0;
      lock_err_reg   <= 1'b0;
      count_reg      <= 16'h0000;
      start_reg      <= 1'b0;
    end else begin
      state_reg      <= state_next;
      ctrl_reg       <= ctrl_next;
      config_reg     <= config_next;
      addr_reg       <= addr_next;
      ready_reg      <= ready_next;
      error_flag_reg <= error_flag_next;
      prog_err_reg   <= prog_err_next;
      lock_err_reg   <= lock_err_next;
      count_reg      <= count_next;
      start_reg      <= start_next;
    end
  end

  // --------------------------------------------------------------
  // region lock bits
  // --------------------------------------------------------------
  // one flop per region; only the addressed region can move in a cycle
  for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_lock
    always_comb begin
      lock_next[g] = lock_reg[g];
      if (lock_upd && (region_idx == RIDX_W'(g))) begin
        lock_next[g] = lock_val;
      end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        lock_reg[g] <= 1'b0;
      end else begin
        lock_reg[g] <= lock_next[g];
      end
    end
  end

  // --------------------------------------------------------------
  // interrupt enables
  // --------------------------------------------------------------
  // separate set and clear offsets, so one write never disturbs the other bit
  always_comb begin
    ien_next = ien_reg;
    if (wr_en && (paddr == nvmcri_pkg::OFF_IRQ_ENABLE_SET)) begin
      ien_next = ien_reg | pwdata[1:0];   // R14
    end
    if (wr_en && (paddr == nvmcri_pkg::OFF_IRQ_ENABLE_CLEAR)) begin
      ien_next = ien_reg & ~pwdata[1:0];  // R14
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ien_reg <= 2'h0;
    end else begin
      ien_reg <= ien_next;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign array_cmd_start = start_reg;
  assign array_cmd_code  = ctrl_reg[nvmcri_pkg::CMD_MSB:nvmcri_pkg::CMD_LSB];
  assign array_word_addr = addr_reg;                                   // R9
  assign array_byte_addr = {addr_reg, 1'b0};                           // R9
  assign mem_stall       = ~ready_reg;                                 // R12
  assign irq = (ready_reg & ien_reg[nvmcri_pkg::IRQ_READY_BIT])
             | (error_flag_reg & ien_reg[nvmcri_pkg::IRQ_ERROR_BIT]); // R15

  // --------------------------------------------------------------
  // register read back
  // --------------------------------------------------------------
  // read mux: combinational so data lands in the access phase
  logic [31:0] lock_word;
  always_comb begin
    lock_word = 32'h0000_0000;
    lock_word[NUM_REGIONS-1:0] = lock_reg;
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_sel) begin
      unique case (paddr)
        nvmcri_pkg::OFF_COMMAND_CONTROL:       prdata = {16'h0000, ctrl_reg};   // R8
        nvmcri_pkg::OFF_CONFIGURATION_CONTROL: prdata = config_reg;
        nvmcri_pkg::OFF_GEOMETRY_PARAMETERS:   prdata = 32'h0000_0000;
        nvmcri_pkg::OFF_IRQ_ENABLE_CLEAR,
        nvmcri_pkg::OFF_IRQ_ENABLE_SET:        prdata = {30'h0, ien_reg};
        nvmcri_pkg::OFF_IRQ_FLAGS:             prdata = {30'h0, error_flag_reg, ready_reg};
        nvmcri_pkg::OFF_CONTROLLER_STATUS:
          prdata = {27'h0, 1'b0, lock_err_reg, prog_err_reg, 2'b00};
        nvmcri_pkg::OFF_TARGET_ADDRESS:        prdata = {10'h000, addr_reg};
        nvmcri_pkg::OFF_REGION_LOCK_STATE:     prdata = lock_word;
        default:                               prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : nvmcri_top

/* File: sim/nvmcri_array_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// array model: busy for a chosen span after each start
// ----------------------------------------------------------------
module nvmcri_array_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // command port
  input  wire logic       start,
  input  wire logic [3:0] busy_len,
  output logic            array_busy
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  always_comb begin
    cnt_next = cnt_reg;
    if (start)
      cnt_next = busy_len;
    else if (cnt_reg != 4'h0)
      cnt_next = cnt_reg - 4'h1;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_next;
  end
  // a driven level at all times, so no stale value is left on the line
  assign array_busy = (cnt_reg != 4'h0);
endmodule : nvmcri_array_model

/* File: sim/nvmcri_top_chk.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// command issue checker
// ----------------------------------------------------------------
module nvmcri_top_chk #(
  parameter int PROG_CYCLES = nvmcri_pkg::PROG_CYCLES,
  parameter int NUM_REGIONS = 16
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [5:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // memory bus, array and interrupt
  input wire logic        mem_access,
  input wire logic        mem_stall,
  input wire logic        array_cmd_start,
  input wire logic [6:0]  array_cmd_code,
  input wire logic [21:0] array_word_addr,
  input wire logic [22:0] array_byte_addr,
  input wire logic        array_busy,
  input wire logic        irq
);
  logic       wr_acc;
  logic       rd_ctrl;
  logic [1:0] en_reg;
  logic [1:0] en_next;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_ctrl = psel && !pwrite && (paddr == 6'h00);
  // enables mirrored here so irq is judged without a bus read
  always_comb begin
    en_next = en_reg;
    if (wr_acc && paddr == 6'h10)
      en_next = en_reg | pwdata[1:0];
    if (wr_acc && paddr == 6'h0c)
      en_next = en_reg & ~pwdata[1:0];
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      en_reg <= 2'h0;
    else
      en_reg <= en_next;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_ctrl_wr;
    wr_acc && paddr == 6'h00 && !mem_stall;
  endsequence
  sequence s_good_wr;
    s_ctrl_wr ##0 pwdata[15:8] == 8'ha5;
  endsequence
  property p_bad_key;
    s_ctrl_wr ##0 pwdata[15:8] != 8'ha5 |=> (!mem_stall && !array_cmd_start) [*3];
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key write not discarded");
  property p_good_start;
    s_good_wr ##0 pwdata[6:0] == 7'h04 ##1 (!mem_access && !array_busy) |=> array_cmd_start;
  endproperty
  a_good_start: assert property (p_good_start) else $error("keyed command not started");
  property p_defer;
    mem_access || array_busy |=> !array_cmd_start;
  endproperty
  a_defer: assert property (p_defer) else $error("start while bus or array busy");
  property p_stall_hold;
    array_cmd_start && (array_cmd_code inside {7'h02, 7'h04, 7'h05, 7'h06, 7'h1a, 7'h1c})
      |-> mem_stall [*4];
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall dropped early");
  property p_ready_back;
    array_cmd_start |-> ##[1:60] !mem_stall;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready never returned");
  property p_key_pend;
    s_good_wr ##1 mem_access ##1 rd_ctrl |-> prdata[15:8] == 8'ha5;
  endproperty
  a_key_pend: assert property (p_key_pend) else $error("pending key read wrong");
  property p_key_issued;
    array_cmd_start && rd_ctrl |-> prdata[15:8] == 8'ha4;
  endproperty
  a_key_issued: assert property (p_key_issued) else $error("issued key read wrong");
  property p_byte_addr;
    array_cmd_start |-> array_byte_addr == {array_word_addr, 1'b0};
  endproperty
  a_byte_addr: assert property (p_byte_addr) else $error("address not in halfwords");
  property p_irq_ready;
    (!mem_stall && en_reg[0]) [*2] |-> irq;
  endproperty
  a_irq_ready: assert property (p_irq_ready) else $error("ready irq missing");
  property p_irq_quiet;
    (en_reg == 2'b00) [*2] |-> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq while disabled");
endmodule : nvmcri_top_chk

bind nvmcri_top nvmcri_top_chk #(.PROG_CYCLES(PROG_CYCLES), .NUM_REGIONS(NUM_REGIONS))
  i_nvmcri_top_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .mem_access(mem_access), .mem_stall(mem_stall), .array_cmd_start(array_cmd_start),
  .array_cmd_code(array_cmd_code), .array_word_addr(array_word_addr),
  .array_byte_addr(array_byte_addr), .array_busy(array_busy), .irq(irq));

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        mem_access = 1'b0;
  logic [5:0]  paddr = 6'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  slow = 4'h0;
  logic [31:0] prdata, v;
  logic        mem_stall, array_cmd_start, array_busy, irq, pready, pslverr;
  logic [6:0]  array_cmd_code;
  logic [21:0] array_word_addr;
  logic [22:0] array_byte_addr;
  int          err_total = 0, total_checks = 0, n_start = 0, n;
  nvmcri_top #(.PROG_CYCLES(3)) i_nvmcri_top (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_access(mem_access), .mem_stall(mem_stall), .array_cmd_start(array_cmd_start),
    .array_cmd_code(array_cmd_code), .array_word_addr(array_word_addr),
    .array_byte_addr(array_byte_addr), .array_busy(array_busy), .irq(irq));
  nvmcri_array_model i_nvmcri_array_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .start(array_cmd_start), .busy_len(slow), .array_busy(array_busy));
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (array_cmd_start === 1'b1) n_start++;
  // ----------------------------------------------------------------
  // bus access: setup, access, data taken at the access edge
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    v = prdata;
    `CHK("slverr", 1'b0, pslverr)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_rdy;
    @(posedge clk_sys);
    for (int i = 0; i < 200 && mem_stall !== 1'b0; i++)
      @(posedge clk_sys);
    `CHK("ready", 1'b0, mem_stall)
  endtask : wait_rdy
  task automatic cmd(input logic [6:0] c);
    wr(6'h00, {16'h0000, 8'ha5, 1'b0, c});
    wait_rdy;
  endtask : cmd
  task automatic clr_err;
    wr(6'h18, 32'h0000_000c);
    wr(6'h14, 32'h0000_0002);
  endtask : clr_err
  task automatic see_irq(input string nm, input logic e);
    repeat (2) @(posedge clk_sys);
    `CHK(nm, e, irq)
  endtask : see_irq
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_badkey;
    rd(6'h00);
    `CHK("ctrl_reset", 32'h0, v)
    rd(6'h14);
    `CHK("flags_reset", 32'h1, v)
    n = n_start;
    wr(6'h00, 32'h0000_5a04);
    repeat (4) @(posedge clk_sys);
    `CHK("no_start", n, n_start)
    rd(6'h00);
    `CHK("ctrl_kept", 32'h0, v)
    rd(6'h18);
    `CHK("prog_err", 1'b1, v[2])
    clr_err;
    rd(6'h18);
    `CHK("err_clear", 2'b00, v[3:2])
  endtask : t_badkey
  // slow array keeps the block busy so the second write lands mid-command
  task automatic t_basic;
    n = n_start;
    slow <= 4'h5;
    wr(6'h1c, 32'h0000_1234);
    wr(6'h00, 32'h0000_a504);
    rd(6'h00);
    `CHK("key_issued", 16'ha404, v[15:0])
    `CHK("stall", 1'b1, mem_stall)
    `CHK("word_addr", 22'h001234, array_word_addr)
    `CHK("byte_addr", 23'h002468, array_byte_addr)
    `CHK("code", 7'h04, array_cmd_code)
    wr(6'h00, 32'h0000_a502);
    wait_rdy;
    `CHK("one_start", n + 1, n_start)
    rd(6'h18);
    `CHK("busy_err", 1'b1, v[2])
    clr_err;
    slow <= 4'h0;
  endtask : t_basic
  task automatic t_defer;
    n = n_start;
    mem_access <= 1'b1;
    wr(6'h00, 32'h0000_a504);
    rd(6'h00);
    `CHK("key_pending", 8'ha5, v[15:8])
    repeat (5) @(posedge clk_sys);
    `CHK("deferred", n, n_start)
    mem_access <= 1'b0;
    wait_rdy;
    `CHK("issued", n + 1, n_start)
  endtask : t_defer
  task automatic t_codes;
    logic [6:0] c [10];
    c = '{7'h02, 7'h04, 7'h05, 7'h06, 7'h1a, 7'h1c, 7'h40, 7'h41, 7'h44, 7'h46};
    wr(6'h1c, 32'h0);
    for (int i = 0; i < 10; i++) begin
      n = n_start;
      cmd(c[i]);
      rd(6'h18);
      `CHK("code_ok", 1'b0, v[2])
      if (i < 6) `CHK("code_run", n + 1, n_start)
    end
    cmd(7'h03);
    rd(6'h18);
    `CHK("reserved", 1'b1, v[2])
    clr_err;
  endtask : t_codes
  task automatic t_lock;
    wr(6'h1c, 32'h0000_1000);
    cmd(7'h40);
    n = n_start;
    cmd(7'h02);
    `CHK("lock_skip", n, n_start)
    rd(6'h18);
    `CHK("lock_err", 1'b1, v[3])
    clr_err;
    cmd(7'h41);
    n = n_start;
    cmd(7'h02);
    `CHK("unlock_run", n + 1, n_start)
  endtask : t_lock
  task automatic t_irq;
    wr(6'h10, 32'h1);
    see_irq("irq_ready", 1'b1);
    wr(6'h0c, 32'h1);
    see_irq("irq_masked", 1'b0);
    wr(6'h10, 32'h2);
    wr(6'h00, 32'h0000_1204);
    see_irq("irq_error", 1'b1);
    wr(6'h10, 32'h0);
    rd(6'h10);
    `CHK("enables", 2'b10, v[1:0])
    clr_err;
    see_irq("irq_cleared", 1'b0);
  endtask : t_irq
  task automatic close_out;
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // the whole sequence needs about three hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_badkey;
    t_basic;
    t_defer;
    t_codes;
    t_lock;
    t_irq;
    close_out;
  end
endmodule : tb_top
